// [rtl/sram_host_pkg.sv]
/*
 Constants for the host controller of a 1K x 4 asynchronous static RAM.
 Assumes a 40 MHz controller clock; times are in ns, counts derived from them.
*/
// Function
// [RULE_01] Memory holds 1024 words of 4 bits, selected by a 10-bit address.
// [RULE_02] Select low and strobe low together write the data pins.
// [RULE_03] Select low with strobe high makes the memory drive read data.
// [RULE_04] Memory floats its data pins while select high or strobe low.
// [RULE_05] Power-saving variant powers down within 20/30 ns while deselected.
// [RULE_06] Non-power-saving variant: select does not change power.
// [RULE_07] Write interval is overlap of select low and strobe low.
// [RULE_08] Host times data setup against the edge that ends the write.
// [RULE_09] Select and strobe rising together leave data pins floating.
// [RULE_10] Read data valid within address access time 25/35/45 ns.
// [RULE_11] Host keeps read address at least read cycle time 25/35/45 ns.
// [RULE_12] Host keeps write address at least write cycle time 25/35/45 ns.
// [RULE_13] Host keeps strobe low at least 20/30/35 ns.
// [RULE_14] Host keeps select low 20/30/40 ns before strobe rises.
// [RULE_15] Address stable 20/30/35 ns before write end; strobe not before address.
// [RULE_16] Host holds address 5 ns after the write ends.
// [RULE_17] Host drives data 12/20/20 ns before write end; no hold needed.
// [RULE_18] Memory floats pins within 8 ns of strobe falling.
// [RULE_19] Memory floats pins within 15/20/20 ns after select rises.
// [RULE_20] Non-power-saving variant: select access within 15/15/20 ns.
// [RULE_21] Fastest power-saving grade: select access 25 or 30 ns.
package sram_host_pkg;
   localparam int CLK_PERIOD_PS = 25000;
   localparam int ADDR_W = 10;
   localparam int DATA_W = 4;
   // Slowest grade figures, so any grade is served
   localparam int ADDR_ACCESS_DELAY_NS = 45;
   localparam int READ_CYCLE_MIN_NS = 45;
   localparam int WRITE_CYCLE_MIN_NS = 45;
   localparam int STROBE_LOW_MIN_NS = 35;
   localparam int SELECT_TO_END_MIN_NS = 40;
   localparam int ADDR_TO_END_MIN_NS = 35;
   localparam int ADDR_HOLD_NS = 5;
   localparam int DATA_SETUP_NS = 20;
   localparam int STROBE_FLOAT_DELAY_NS = 8;
   localparam int DESELECT_FLOAT_DELAY_NS = 20;
   localparam int SELECT_ACCESS_NS = 45;
   localparam int POWERDOWN_DELAY_NS = 30;
   localparam int DESELECT_LONG_NS = 25;
   // Least times round up
   localparam int READ_CYC = (READ_CYCLE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int ACCESS_CYC =
      (((ADDR_ACCESS_DELAY_NS > SELECT_ACCESS_NS) ? ADDR_ACCESS_DELAY_NS : SELECT_ACCESS_NS)
       * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int STROBE_CYC = (STROBE_LOW_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int SEL_END_CYC =
      (SELECT_TO_END_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int WRITE_CYC = (WRITE_CYCLE_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int HOLD_CYC = (ADDR_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int FLOAT_CYC =
      (DESELECT_FLOAT_DELAY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int CNT_W = 4;
   localparam logic [3:0] CNT_ZERO = 4'h0;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_READ = 3'b001,
      ST_WRITE = 3'b010,
      ST_HOLD = 3'b011,
      ST_GAP = 3'b100
   } host_state_t;
endpackage

// [rtl/sram_host.sv]
/*
 Host controller driving a 1K x 4 asynchronous static RAM through its pins.
 Assumes the memory's data pins are resolved by the bench from the enable;
 user requests are synchronous to mclk and held until acknowledged.
*/
`timescale 1ns/1ps
`default_nettype none
module sram_host
   import sram_host_pkg::*;
#(
   parameter int ADDR_BITS = ADDR_W,
   parameter int DATA_BITS = DATA_W
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic req,
   input wire logic req_write,
   input wire logic [ADDR_BITS-1:0] req_addr,
   input wire logic [DATA_BITS-1:0] req_wdata,
   output logic ack,
   output logic busy,
   output logic [DATA_BITS-1:0] rdata,
   output logic [ADDR_BITS-1:0] mem_addr,
   output logic mem_select_n,
   output logic mem_strobe_n,
   output logic [DATA_BITS-1:0] mem_data_out,
   output logic mem_data_oe,
   input wire logic [DATA_BITS-1:0] mem_data_in
);
   ////////////////////////////////////////////////////////////////////////////
   // Elaboration checks
   localparam int CNT_MAX = (1 << CNT_W) - 1;

   // Array shape is fixed by the memory
   if (ADDR_BITS != ADDR_W) begin : g_addr_bits_check
      $error("sram_host: the memory takes a 10-bit word address");
   end

   if (DATA_BITS != DATA_W) begin : g_data_bits_check
      $error("sram_host: the memory has 4-bit words");
   end

   // Counter literals are sized for this width
   if (CNT_W != $bits(CNT_ZERO)) begin : g_cnt_width_check
      $error("sram_host: wait counter width does not match its literals");
   end

   // Every wait spans at least one clock and fits the counter
   if (ACCESS_CYC < 1 || ACCESS_CYC > CNT_MAX) begin : g_access_check
      $error("sram_host: access wait out of counter range");
   end

   if (READ_CYC < 1 || READ_CYC > CNT_MAX) begin : g_read_check
      $error("sram_host: read cycle wait out of counter range");
   end

   if (STROBE_CYC < 1 || STROBE_CYC > CNT_MAX) begin : g_strobe_check
      $error("sram_host: strobe wait out of counter range");
   end

   if (SEL_END_CYC < 1 || SEL_END_CYC > CNT_MAX) begin : g_select_check
      $error("sram_host: select wait out of counter range");
   end

   if (WRITE_CYC < 1 || WRITE_CYC > CNT_MAX) begin : g_write_check
      $error("sram_host: write cycle wait out of counter range");
   end

   if (HOLD_CYC < 1 || HOLD_CYC > CNT_MAX) begin : g_hold_check
      $error("sram_host: address hold wait out of counter range");
   end

   if (FLOAT_CYC < 1 || FLOAT_CYC > CNT_MAX) begin : g_float_check
      $error("sram_host: release wait out of counter range");
   end

   typedef struct packed {
      host_state_t st;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] cyc;
      logic ack;
      logic busy;
      logic [DATA_BITS-1:0] rdata;
      logic [ADDR_BITS-1:0] addr;
      logic sel_n;
      logic stb_n;
      logic [DATA_BITS-1:0] dout;
      logic oe;
   } host_regs_t;

   host_regs_t s_r;
   host_regs_t s_nxt;

   function automatic logic [CNT_W-1:0] cyc_of(input int n);
      return CNT_W'(n);
   endfunction

   // True once a wait counter has spanned n clock periods
   function automatic logic reached(input logic [CNT_W-1:0] count, input int n);
      return count >= cyc_of(n - 1);
   endfunction

   // Parked pins: deselected, strobe high, data pins released
   function automatic host_regs_t idle_regs();
      host_regs_t r;
      r = '{st: ST_IDLE, cnt: CNT_ZERO, cyc: CNT_ZERO, ack: 1'b0, busy: 1'b0, rdata: '0,
            addr: '0, sel_n: 1'b1, stb_n: 1'b1, dout: '0, oe: 1'b0};
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Wait conditions of each phase
   logic read_done;
   logic strobe_done;
   logic hold_done;
   logic gap_done;

   assign read_done = reached(s_r.cnt, ACCESS_CYC)             // RULE_10
                      && reached(s_r.cyc, READ_CYC);           // RULE_11
   assign strobe_done = reached(s_r.cnt, STROBE_CYC)           // RULE_13
                        && reached(s_r.cnt, SEL_END_CYC);      // RULE_14
   assign hold_done = reached(s_r.cnt, HOLD_CYC)               // RULE_16
                      && reached(s_r.cyc, WRITE_CYC);          // RULE_12
   assign gap_done = reached(s_r.cnt, FLOAT_CYC);              // RULE_19

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_nxt = s_r;
      s_nxt.ack = 1'b0;
      s_nxt.cnt = s_r.cnt + 4'h1;
      s_nxt.cyc = s_r.cyc + 4'h1;
      case (s_r.st)
         ST_IDLE: begin
            // Take a request and drive the pins for it
            s_nxt.cnt = CNT_ZERO;
            if (req) begin
               s_nxt.busy = 1'b1;
               s_nxt.addr = req_addr;                         // RULE_01
               s_nxt.sel_n = 1'b0;
               s_nxt.cyc = CNT_ZERO;
               if (req_write) begin
                  // Strobe falls with address valid, never earlier
                  s_nxt.stb_n = 1'b0;                         // RULE_15
                  s_nxt.dout = req_wdata;                     // RULE_17
                  s_nxt.oe = 1'b1;                            // RULE_02
                  s_nxt.st = ST_WRITE;
               end else begin
                  s_nxt.stb_n = 1'b1;                         // RULE_03
                  s_nxt.oe = 1'b0;                            // RULE_04
                  s_nxt.st = ST_READ;
               end
            end
         end
         ST_READ: begin
            // Sample once both access times and the read cycle have passed
            if (read_done) begin
               s_nxt.rdata = mem_data_in;                     // RULE_10
               s_nxt.sel_n = 1'b1;
               s_nxt.ack = 1'b1;
               s_nxt.cnt = CNT_ZERO;
               s_nxt.st = ST_GAP;                             // RULE_11
            end
         end
         ST_WRITE: begin
            // Strobe ends the write, select kept low past it
            if (strobe_done) begin
               s_nxt.stb_n = 1'b1;                            // RULE_07
               // Pins freed with the strobe; memory may drive at once
               s_nxt.oe = 1'b0;                               // RULE_17
               s_nxt.cnt = CNT_ZERO;
               s_nxt.st = ST_HOLD;                            // RULE_08
            end
         end
         ST_HOLD: begin
            // Address held after the strobe edge; data pins already released with it
            if (hold_done) begin
               s_nxt.sel_n = 1'b1;                            // RULE_16
               s_nxt.oe = 1'b0;
               s_nxt.ack = 1'b1;
               s_nxt.cnt = CNT_ZERO;
               s_nxt.st = ST_GAP;                             // RULE_12
            end
         end
         ST_GAP: begin
            // Let the memory release its pins before any next access
            if (gap_done) begin
               s_nxt.busy = 1'b0;                             // RULE_19
               s_nxt.st = ST_IDLE;
            end
         end
         default: begin
            // Unknown code: park the pins
            s_nxt = idle_regs();
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge mclk) begin
      if (!reset_n) begin
         s_r <= idle_regs();
      end else if (clk_en) begin
         s_r <= s_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs straight from the state register
   assign ack = s_r.ack;
   assign busy = s_r.busy;
   assign rdata = s_r.rdata;
   // Memory pins
   assign mem_addr = s_r.addr;
   assign mem_select_n = s_r.sel_n;
   assign mem_strobe_n = s_r.stb_n;
   assign mem_data_out = s_r.dout;
   assign mem_data_oe = s_r.oe;
endmodule
`default_nettype wire

// [testbench/sram_host_assertions.sv]
/* Pin checks for sram_host.
   Bound to the host's ports; one clock, synchronous reset. */
`timescale 1ns/1ps
`default_nettype none
module sram_host_assertions #(
   parameter int ADDR_BITS = 10,
   parameter int DATA_BITS = 4
) (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic clk_en,
   input wire logic ack,
   input wire logic busy,
   input wire logic [DATA_BITS-1:0] rdata,
   input wire logic [ADDR_BITS-1:0] mem_addr,
   input wire logic mem_select_n,
   input wire logic mem_strobe_n,
   input wire logic mem_data_oe
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!reset_n);
   strobe_in_select_a: assert property (!mem_strobe_n |-> !mem_select_n)
      else $error("strobe low while deselected");
   strobe_width_a: assert property ($fell(mem_strobe_n) |-> !mem_strobe_n [*2])
      else $error("strobe pulse too short");
   strobe_data_a: assert property (!mem_strobe_n |-> mem_data_oe)
      else $error("strobe low without write data");
   write_end_a: assert property ($past(reset_n) && $rose(mem_strobe_n)
      |-> !mem_select_n && $past(mem_data_oe)) else $error("write not ended by strobe");
   addr_stable_a: assert property (!mem_select_n && !$past(mem_select_n)
      |-> $stable(mem_addr)) else $error("address moved while selected");
   addr_hold_a: assert property ($past(reset_n) && $rose(mem_select_n)
      |-> $stable(mem_addr)) else $error("address moved at deselect");
   drive_clash_a: assert property (!mem_select_n && mem_strobe_n |-> !mem_data_oe)
      else $error("host drives pins while memory may drive");
   read_float_a: assert property ($fell(mem_select_n) && mem_strobe_n |-> !mem_data_oe)
      else $error("host drives pins in read");
   ack_pulse_a: assert property (ack && clk_en |=> !ack && mem_select_n)
      else $error("ack not a single pulse");
   rdata_hold_a: assert property ($past(reset_n) && !ack |-> $stable(rdata))
      else $error("read data changed without ack");
   cover property ($fell(mem_select_n) && mem_strobe_n ##2 ack);
   cover property ($rose(mem_strobe_n) ##1 ack);
   cover property (busy && !clk_en);
endmodule
bind sram_host sram_host_assertions #(.ADDR_BITS(ADDR_BITS), .DATA_BITS(DATA_BITS))
   sram_host_assertions_inst (.*);
`default_nettype wire

// [testbench/sram_model.sv]
/* Behavioural 1K x 4 static memory at the host's pins.
   Resolves the data pins from both parties' enables. */
`timescale 1ns/1ps
`default_nettype none
module sram_model #(
   parameter int ACC_NS = 45
) (
   input wire logic [9:0] addr,
   input wire logic select_n,
   input wire logic strobe_n,
   input wire logic [3:0] host_data,
   input wire logic host_oe,
   output logic [3:0] pin_level
);
   logic [3:0] mem [1024];
   logic valid = 1'b0;
   wire write_on = !select_n && !strobe_n;
   wire drive = !select_n && strobe_n && valid;
   always @(negedge write_on) mem[addr] = host_data;
   always @(addr, select_n) begin
      valid = 1'b0;
      valid <= #(ACC_NS) 1'b1;
   end
   // Undriven pins show the inverse of the stored word
   assign pin_level = host_oe ? host_data : drive ? mem[addr] : ~mem[addr];
endmodule
`default_nettype wire

// [testbench/tb.sv]
/* Bench for sram_host with sram_model on its memory pins.
   Assumes a 40 MHz mclk and the host's fixed ack latencies. */
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic mclk = 0, reset_n = 0, clk_en = 1, req = 0, req_write = 0, ack, busy;
   logic mem_select_n, mem_strobe_n, mem_data_oe;
   logic [9:0] req_addr = 10'h000, mem_addr;
   logic [3:0] req_wdata = 4'h0, rdata, mem_data_out, mem_data_in;
   int errors = 0, samples_checked = 0;
   sram_host sram_host_inst (.*);
   sram_model sram_model_inst (.addr(mem_addr), .select_n(mem_select_n),
      .strobe_n(mem_strobe_n), .host_data(mem_data_out), .host_oe(mem_data_oe),
      .pin_level(mem_data_in));
   initial forever #12.5 mclk = ~mclk;
   initial begin
      #100us;
      errors++;
      end_of_test();
   end
   task automatic check(input logic ok, input string what);
      samples_checked++;
      if (ok !== 1'b1) begin
         errors++;
         $display("BAD %0t %s", $time, what);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic op(input logic w, input logic [9:0] a, input logic [3:0] d, input int lat);
      int n;
      repeat (2) @(posedge mclk) #1;
      {req, req_write, req_addr, req_wdata} = {1'b1, w, a, d};
      @(posedge mclk) #1;
      req = 1'b0;
      for (n = 0; n < 9 && ack !== 1'b1; n++) @(posedge mclk) #1;
      check(n == lat, "ack latency");
      if (!w) check(rdata === d, "read data");
   endtask
   task automatic test_write_read;
      logic [9:0] a [4] = '{10'h000, 10'h3FF, 10'h155, 10'h2AA};
      logic [3:0] d [4] = '{4'hA, 4'h5, 4'hF, 4'h0};
      for (int i = 0; i < 4; i++) op(1'b1, a[i], d[i], 3);
      for (int i = 0; i < 4; i++) op(1'b0, a[i], d[i], 2);
      $display("write_read done");
   endtask
   task automatic test_freeze;
      repeat (2) @(posedge mclk) #1;
      {req, req_write, req_addr} = {1'b1, 1'b0, 10'h155};
      @(posedge mclk) #1;
      {req, clk_en} = 2'b00;
      repeat (4) @(posedge mclk) #1;
      check({ack, busy, mem_select_n} === 3'b010, "frozen read");
      clk_en = 1'b1;
      repeat (2) @(posedge mclk) #1;
      check({ack, rdata} === {1'b1, 4'hF}, "read after freeze");
      $display("freeze done");
   endtask
   task automatic test_reset_mid;
      repeat (2) @(posedge mclk) #1;
      {req, req_write, req_addr, req_wdata} = {1'b1, 1'b1, 10'h0F0, 4'h9};
      repeat (2) @(posedge mclk) #1;
      {req, reset_n} = 2'b00;
      @(posedge mclk) #1;
      reset_n = 1'b1;
      check({mem_select_n, mem_strobe_n, mem_data_oe, ack, busy} === 5'h18, "reset");
      $display("reset_mid done");
   endtask
   initial begin
      repeat (20) @(posedge mclk);
      #1 reset_n = 1'b1;
      check({mem_select_n, mem_strobe_n, mem_data_oe, ack, busy} === 5'h18, "idle");
      test_write_read();
      test_freeze();
      test_reset_mid();
      end_of_test();
   end
endmodule
`default_nettype wire
